// [rpfs_pkg.sv]
// Shared constants for the radio payload FIFO and status block
package rpfs_pkg;
  localparam logic [7:0] ADDR_PIPE4_PW = 8'h15;
  localparam logic [7:0] ADDR_PIPE5_PW = 8'h16;
  localparam logic [7:0] ADDR_FIFO_FLAGS = 8'h17;
  localparam logic [5:0] PW_RESET = 6'h00;
  localparam logic [5:0] PW_MAX = 6'h20;
  localparam int BIT_REUSE = 6;
  localparam int BIT_TX_FULL = 5;
  localparam int BIT_TX_EMPTY = 4;
  localparam int BIT_RX_FULL = 1;
  localparam int BIT_RX_EMPTY = 0;
  localparam int FIFO_DEPTH = 3;
  localparam int SLOT_BITS = 256;
  localparam logic [7:0] CMD_RD_REG = 8'h01;
  localparam logic [7:0] CMD_WR_REG = 8'h02;
  localparam logic [7:0] CMD_WR_TX = 8'h03;
  localparam logic [7:0] CMD_WR_ACK = 8'h04;
  localparam logic [7:0] CMD_FLUSH_TX = 8'h05;
  localparam logic [7:0] CMD_FLUSH_RX = 8'h06;
  localparam logic [7:0] CMD_REUSE = 8'h07;
  localparam logic [7:0] CMD_RD_RX = 8'h08;
  localparam int CE_MIN_NS = 10000;
  localparam int CLK_NS = 5;
  localparam int CE_MIN_CYC = (CE_MIN_NS + CLK_NS - 1) / CLK_NS;
endpackage : rpfs_pkg

// [rpfs_buf2.sv]
// Two-entry valid/ready skid buffer
module rpfs_buf2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_ff [2];
  logic rd_ff;
  logic wr_ff;
  logic [1:0] cnt_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_ff != 2'd2);
  assign out_valid = (cnt_ff != 2'd0);
  assign out_data = mem_ff[rd_ff];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      cnt_ff <= 2'd0;
    end else begin
      if (push) wr_ff <= ~wr_ff;
      if (pop) rd_ff <= ~rd_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem_ff[wr_ff] <= in_data;
  end
  if (W < 1) begin : g_w_chk
    $error("rpfs_buf2: W must be positive");
  end
  buf_bound_a: assert property (@(posedge clk) disable iff (!rst_n) cnt_ff <= 2'd2)
    else $error("buffer count above two");
endmodule : rpfs_buf2

// [rpfs_core.sv]
// Payload FIFOs, pipe widths and FIFO status flags of the radio
module rpfs_core #(
  parameter int DEPTH = rpfs_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic [255:0] cmd_payload,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_rdata,
  output logic [255:0] rsp_payload,
  input wire logic tx_mode,
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic radio_en,
  input wire logic rx_push,
  input wire logic [255:0] rx_push_data,
  output logic rx_push_ready,
  output logic ack_valid,
  output logic [255:0] ack_data,
  input wire logic ack_pop,
  output logic tx_send,
  output logic [255:0] tx_data
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_C = CW'(1);
  localparam logic [CW-1:0] ZERO_C = '0;
  localparam logic [15:0] CE_CYC = 16'(rpfs_pkg::CE_MIN_CYC);

  if (DEPTH < 1 || DEPTH > 3) begin : g_depth_chk
    $error("rpfs_core: DEPTH must be 1 to 3");
  end

  logic [5:0] pipe4_pw_ff;
  logic [5:0] pipe5_pw_ff;
  logic reuse_ff;
  logic [255:0] tx_mem_ff [DEPTH];
  logic [255:0] rx_mem_ff [DEPTH];
  logic [255:0] ack_store_ff;
  logic ack_valid_ff;
  logic [1:0] tx_rd_ff;
  logic [1:0] tx_wr_ff;
  logic [1:0] rx_rd_ff;
  logic [1:0] rx_wr_ff;
  logic [CW-1:0] tx_cnt_ff;
  logic [CW-1:0] rx_cnt_ff;
  logic [255:0] tx_data_ff;
  logic tx_send_ff;

  // Radio enable pulse is measured in the link domain and handed over as a toggle
  logic ce_s1_ff;
  logic ce_s2_ff;
  logic ce_s3_ff;
  logic [15:0] ce_cnt_ff;
  logic ce_tgl_ff;
  logic ce_done_ff;
  logic [15:0] nxt_ce_cnt;
  wire ce_agree = (ce_s2_ff == ce_s3_ff);
  wire ce_high = ce_agree && ce_s3_ff;
  wire ce_long = (ce_cnt_ff >= CE_CYC - 16'h0001);
  assign nxt_ce_cnt = ce_high ? (ce_long ? ce_cnt_ff : ce_cnt_ff + 16'h0001) : 16'h0000;
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      ce_s1_ff <= 1'b0;
      ce_s2_ff <= 1'b0;
      ce_s3_ff <= 1'b0;
      ce_cnt_ff <= 16'h0000;
      ce_tgl_ff <= 1'b0;
      ce_done_ff <= 1'b0;
    end else begin
      ce_s1_ff <= radio_en;
      ce_s2_ff <= ce_s1_ff;
      ce_s3_ff <= ce_s2_ff;
      ce_cnt_ff <= nxt_ce_cnt;
      // One send request per qualifying pulse
      if (ce_high && ce_long && !ce_done_ff) begin
        ce_tgl_ff <= ~ce_tgl_ff;
        ce_done_ff <= 1'b1;
      end else if (!ce_high) begin
        ce_done_ff <= 1'b0;
      end
    end
  end

  logic tg_s1_ff;
  logic tg_s2_ff;
  logic tg_s3_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tg_s1_ff <= 1'b0;
      tg_s2_ff <= 1'b0;
      tg_s3_ff <= 1'b0;
    end else begin
      tg_s1_ff <= ce_tgl_ff;
      tg_s2_ff <= tg_s1_ff;
      tg_s3_ff <= tg_s2_ff;
    end
  end
  wire send_req = (tg_s2_ff != tg_s3_ff);

  // Command decode
  wire cmd_go = cmd_valid && cmd_ready;
  wire op_wr_reg = cmd_go && (cmd_op == rpfs_pkg::CMD_WR_REG);
  wire op_rd_reg = cmd_go && (cmd_op == rpfs_pkg::CMD_RD_REG);
  wire op_wr_tx = cmd_go && (cmd_op == rpfs_pkg::CMD_WR_TX);
  wire op_wr_ack = cmd_go && (cmd_op == rpfs_pkg::CMD_WR_ACK);
  wire op_flush_tx = cmd_go && (cmd_op == rpfs_pkg::CMD_FLUSH_TX);
  wire op_flush_rx = cmd_go && (cmd_op == rpfs_pkg::CMD_FLUSH_RX);
  wire op_reuse = cmd_go && (cmd_op == rpfs_pkg::CMD_REUSE);
  wire op_rd_rx = cmd_go && (cmd_op == rpfs_pkg::CMD_RD_RX);
  wire sel_p4 = (cmd_addr == rpfs_pkg::ADDR_PIPE4_PW);
  wire sel_p5 = (cmd_addr == rpfs_pkg::ADDR_PIPE5_PW);
  wire sel_flags = (cmd_addr == rpfs_pkg::ADDR_FIFO_FLAGS);

  wire tx_full = (tx_cnt_ff == DEPTH_C);
  wire tx_empty = (tx_cnt_ff == ZERO_C);
  wire rx_full = (rx_cnt_ff == DEPTH_C);
  wire rx_empty = (rx_cnt_ff == ZERO_C);

  // Write only when there is room; a full FIFO drops the payload
  wire tx_push = op_wr_tx && !tx_full;
  // Send: reuse keeps the head entry, otherwise the head is consumed
  wire tx_fire = send_req && tx_mode && !tx_empty && !tx_send_ff;
  wire tx_pop = tx_fire && !reuse_ff && !op_flush_tx;
  wire rx_pop = op_rd_rx && !rx_empty;
  wire rx_wr = rx_push && !rx_full && !op_flush_rx;
  assign rx_push_ready = !rx_full;

  // Status byte; reserved bits always read zero
  logic [7:0] flags_rd;
  always_comb begin
    flags_rd = 8'h00;
    flags_rd[rpfs_pkg::BIT_REUSE] = reuse_ff;
    flags_rd[rpfs_pkg::BIT_TX_FULL] = tx_full;
    flags_rd[rpfs_pkg::BIT_TX_EMPTY] = tx_empty;
    flags_rd[rpfs_pkg::BIT_RX_FULL] = rx_full;
    flags_rd[rpfs_pkg::BIT_RX_EMPTY] = rx_empty;
  end
  wire [7:0] reg_rd = sel_p4 ? {2'b00, pipe4_pw_ff} :
                      sel_p5 ? {2'b00, pipe5_pw_ff} :
                      sel_flags ? flags_rd : 8'h00;
  wire [5:0] wr_pw = (cmd_wdata[5:0] > rpfs_pkg::PW_MAX) ? rpfs_pkg::PW_MAX : cmd_wdata[5:0];

  // Answers go through a two-entry buffer; a stalled reader blocks new commands
  logic buf_in_ready;
  wire rsp_load = op_rd_reg || op_rd_rx;
  assign cmd_ready = buf_in_ready;
  logic [263:0] rsp_word;
  assign rsp_word = {op_rd_rx ? 8'h00 : reg_rd, rx_pop ? rx_mem_ff[rx_rd_ff] : 256'h0};
  logic [263:0] rsp_out;
  rpfs_buf2 #(.W(264)) u_rsp_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rsp_load),
    .in_ready(buf_in_ready),
    .in_data(rsp_word),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp_out)
  );
  assign rsp_rdata = rsp_out[263:256];
  assign rsp_payload = rsp_out[255:0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pipe4_pw_ff <= rpfs_pkg::PW_RESET;
      pipe5_pw_ff <= rpfs_pkg::PW_RESET;
    end else if (op_wr_reg) begin
      if (sel_p4) pipe4_pw_ff <= wr_pw;
      if (sel_p5) pipe5_pw_ff <= wr_pw;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reuse_ff <= 1'b0;
    end else if (op_reuse) begin
      reuse_ff <= 1'b1;
    end else if (op_wr_tx || op_flush_tx) begin
      reuse_ff <= 1'b0;
    end
  end

  function automatic logic [1:0] wrap(input logic [1:0] p);
    wrap = (p == 2'(DEPTH - 1)) ? 2'd0 : p + 2'd1;
  endfunction : wrap

  always_ff @(posedge clk) begin
    if (!rst_n || op_flush_tx) begin
      tx_rd_ff <= 2'd0;
      tx_wr_ff <= 2'd0;
      tx_cnt_ff <= ZERO_C;
    end else begin
      if (tx_push) tx_wr_ff <= wrap(tx_wr_ff);
      if (tx_pop) tx_rd_ff <= wrap(tx_rd_ff);
      tx_cnt_ff <= tx_cnt_ff + (tx_push ? ONE_C : ZERO_C) - (tx_pop ? ONE_C : ZERO_C);
    end
  end

  always_ff @(posedge clk) begin
    if (tx_push) tx_mem_ff[tx_wr_ff] <= cmd_payload;
    if (rx_wr) rx_mem_ff[rx_wr_ff] <= rx_push_data;
  end

  always_ff @(posedge clk) begin
    if (!rst_n || op_flush_rx) begin
      rx_rd_ff <= 2'd0;
      rx_wr_ff <= 2'd0;
      rx_cnt_ff <= ZERO_C;
    end else begin
      if (rx_wr) rx_wr_ff <= wrap(rx_wr_ff);
      if (rx_pop) rx_rd_ff <= wrap(rx_rd_ff);
      rx_cnt_ff <= rx_cnt_ff + (rx_wr ? ONE_C : ZERO_C) - (rx_pop ? ONE_C : ZERO_C);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_store_ff <= 256'h0;
      ack_valid_ff <= 1'b0;
    end else if (op_wr_ack) begin
      ack_store_ff <= cmd_payload;
      ack_valid_ff <= 1'b1;
    end else if (ack_pop) begin
      ack_valid_ff <= 1'b0;
    end
  end
  assign ack_valid = ack_valid_ff;
  assign ack_data = ack_store_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_send_ff <= 1'b0;
      tx_data_ff <= 256'h0;
    end else begin
      tx_send_ff <= tx_fire;
      if (tx_fire) tx_data_ff <= tx_mem_ff[tx_rd_ff];
    end
  end
  assign tx_send = tx_send_ff;
  assign tx_data = tx_data_ff;

  // Checks
  pipe_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    pipe4_pw_ff <= rpfs_pkg::PW_MAX && pipe5_pw_ff <= rpfs_pkg::PW_MAX)
    else $error("pipe width above limit");
  reuse_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    op_reuse |=> reuse_ff)
    else $error("reuse flag not set");
  reuse_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (op_wr_tx || op_flush_tx) && !op_reuse |=> !reuse_ff)
    else $error("reuse flag not cleared");
  tx_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    op_wr_tx && tx_full && !tx_pop |=> tx_full)
    else $error("tx full flag dropped on write");
  tx_empty_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> tx_empty)
    else $error("tx empty not set after reset");
  rx_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_push && rx_full && !rx_pop && !op_flush_rx |=> rx_full)
    else $error("rx full flag dropped on push");
  rx_empty_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_empty && !rx_wr && !op_flush_rx |=> rx_empty)
    else $error("rx empty dropped without write");
  tx_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    tx_push && !tx_pop && !op_flush_tx |=> tx_cnt_ff == $past(tx_cnt_ff) + ONE_C)
    else $error("tx count did not grow");
  tx_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    !tx_mode && !op_flush_tx |=> tx_cnt_ff >= $past(tx_cnt_ff))
    else $error("tx consumed outside transmit");
  reuse_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    reuse_ff && tx_fire && !op_flush_tx |=> tx_cnt_ff == $past(tx_cnt_ff) || $past(tx_push))
    else $error("reused payload consumed");
  ack_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    op_wr_ack |=> ack_valid && ack_data == $past(cmd_payload))
    else $error("ack payload not held");
  rx_pop_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_pop && !rx_wr |=> rx_cnt_ff == $past(rx_cnt_ff) - ONE_C)
    else $error("rx count did not drop");
  ce_pulse_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    $changed(ce_tgl_ff) |-> ce_cnt_ff >= CE_CYC - 16'h0001)
    else $error("send on short enable pulse");
  tx_fill_c: cover property (@(posedge clk) disable iff (!rst_n) tx_full);
  rx_fill_c: cover property (@(posedge clk) disable iff (!rst_n) rx_full);
  reuse_send_c: cover property (@(posedge clk) disable iff (!rst_n) reuse_ff && tx_fire);
  rsp_stall_c: cover property (@(posedge clk) disable iff (!rst_n) !cmd_ready);
  idle_send_c: cover property (@(posedge clk) disable iff (!rst_n) send_req && !tx_mode);
endmodule : rpfs_core

// [rpfs_ctl_model.sv]
// Controller model: pulses the radio enable pin on request
module rpfs_ctl_model #(
  parameter int HOLD = rpfs_pkg::CE_MIN_CYC + 8
) (
  input wire logic link_clk,
  input wire logic go,
  output logic radio_en
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_ff;
  initial begin
    radio_en = 1'b0;
    cnt_ff = 0;
  end
  // Pulse outlasts the minimum high time by a margin of a few link cycles
  always @(posedge link_clk) begin
    if (go && cnt_ff == 0) begin
      radio_en <= 1'b1;
      cnt_ff <= HOLD;
    end else if (cnt_ff > 0) begin
      cnt_ff <= cnt_ff - 1;
      radio_en <= (cnt_ff > 1);
    end
  end
endmodule : rpfs_ctl_model

// [test_radio_payload_fifo_status.sv]
// Testbench for the radio payload FIFO and status block
module test_radio_payload_fifo_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, link_clk = 1'b0, link_rst_n = 1'b0;
  logic cmd_valid = 1'b0, rsp_ready = 1'b1, tx_mode = 1'b0;
  logic rx_push = 1'b0, ack_pop = 1'b0, go = 1'b0;
  logic [7:0] cmd_op = 8'h00, cmd_addr = 8'h00, cmd_wdata = 8'h00;
  logic [255:0] cmd_payload = 256'h0, rx_push_data = 256'h0;
  logic cmd_ready, rsp_valid, rx_push_ready, ack_valid, tx_send, radio_en;
  logic [7:0] rsp_rdata;
  logic [255:0] rsp_payload, ack_data, tx_data;
  int num_errors = 0, tests_run = 0;

  always #2.5 clk = ~clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end

  rpfs_core u_dut (.clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata,
    .cmd_payload, .rsp_valid, .rsp_ready, .rsp_rdata, .rsp_payload, .tx_mode, .link_clk,
    .link_rst_n, .radio_en, .rx_push, .rx_push_data, .rx_push_ready, .ack_valid, .ack_data,
    .ack_pop, .tx_send, .tx_data);
  rpfs_ctl_model u_ctl (.link_clk, .go, .radio_en);

  function automatic logic [255:0] pl(input logic [7:0] b);
    return {32{b}};
  endfunction : pl

  task automatic complete_run;
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (s !== 1'b1) begin
      num_errors++;
      complete_run();
    end
  endtask : wait_hi

  // One idle edge first, then the request is held until the edge that samples ready high
  task automatic cmd(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d,
      input logic [255:0] p);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_payload = p;
    wait_hi(cmd_ready);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : cmd

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cmd(rpfs_pkg::CMD_RD_REG, a, 8'h00, 256'h0);
    wait_hi(rsp_valid);
    chk({248'h0, rsp_rdata}, {248'h0, e});
  endtask : rd

  // One enable pulse; counts transmit strobes over the whole pulse
  task automatic send(input logic m, input logic ex, input logic [255:0] ed);
    int seen;
    logic [255:0] got;
    seen = 0;
    got = 256'h0;
    tx_mode = m;
    go = 1'b1;
    repeat (8) @(negedge clk);
    go = 1'b0;
    repeat (14000) begin
      @(negedge clk);
      if (tx_send === 1'b1) begin
        seen++;
        got = tx_data;
      end
    end
    chk(256'(seen), {255'h0, ex});
    if (ex) begin
      chk(got, ed);
    end
  endtask : send

  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    link_rst_n = 1'b1;
    rd(rpfs_pkg::ADDR_FIFO_FLAGS, 8'h11);
    rd(rpfs_pkg::ADDR_PIPE4_PW, 8'h00);
    rd(rpfs_pkg::ADDR_PIPE5_PW, 8'h00);
    cmd(rpfs_pkg::CMD_WR_REG, rpfs_pkg::ADDR_PIPE4_PW, 8'h20, 256'h0);
    rd(rpfs_pkg::ADDR_PIPE4_PW, 8'h20);
    cmd(rpfs_pkg::CMD_WR_REG, rpfs_pkg::ADDR_PIPE5_PW, 8'h3F, 256'h0);
    rd(rpfs_pkg::ADDR_PIPE5_PW, 8'h20);
    cmd(rpfs_pkg::CMD_WR_REG, rpfs_pkg::ADDR_PIPE5_PW, 8'h01, 256'h0);
    rd(rpfs_pkg::ADDR_PIPE5_PW, 8'h01);
    cmd(rpfs_pkg::CMD_WR_REG, rpfs_pkg::ADDR_FIFO_FLAGS, 8'hFF, 256'h0);
    rd(rpfs_pkg::ADDR_FIFO_FLAGS, 8'h11);
    for (int i = 1; i <= 4; i++) begin
      cmd(rpfs_pkg::CMD_WR_TX, 8'h00, 8'h00, pl(8'(i)));
    end
    rd(rpfs_pkg::ADDR_FIFO_FLAGS, 8'h21);
    send(1'b0, 1'b0, 256'h0);
    send(1'b1, 1'b1, pl(8'h01));
    rd(rpfs_pkg::ADDR_FIFO_FLAGS, 8'h01);
    cmd(rpfs_pkg::CMD_REUSE, 8'h00, 8'h00, 256'h0);
    rd(rpfs_pkg::ADDR_FIFO_FLAGS, 8'h41);
    send(1'b1, 1'b1, pl(8'h02));
    rd(rpfs_pkg::ADDR_FIFO_FLAGS, 8'h41);
    cmd(rpfs_pkg::CMD_FLUSH_TX, 8'h00, 8'h00, 256'h0);
    rd(rpfs_pkg::ADDR_FIFO_FLAGS, 8'h11);
    cmd(rpfs_pkg::CMD_REUSE, 8'h00, 8'h00, 256'h0);
    cmd(rpfs_pkg::CMD_WR_TX, 8'h00, 8'h00, pl(8'h05));
    rd(rpfs_pkg::ADDR_FIFO_FLAGS, 8'h01);
    // Reader stalls: two answers fill the buffer and further commands wait
    @(negedge clk);
    rsp_ready = 1'b0;
    cmd(rpfs_pkg::CMD_RD_REG, rpfs_pkg::ADDR_FIFO_FLAGS, 8'h00, 256'h0);
    cmd(rpfs_pkg::CMD_RD_REG, rpfs_pkg::ADDR_PIPE4_PW, 8'h00, 256'h0);
    @(negedge clk);
    chk({255'h0, cmd_ready}, 256'h0);
    chk({248'h0, rsp_rdata}, 256'h01);
    rsp_ready = 1'b1;
    @(negedge clk);
    chk({248'h0, rsp_rdata}, 256'h20);
    repeat (2) @(negedge clk);
    chk({255'h0, rsp_valid}, 256'h0);
    for (int i = 0; i < 4; i++) begin
      rx_push = 1'b1;
      rx_push_data = pl(8'hA0 + 8'(i));
      @(negedge clk);
    end
    rx_push = 1'b0;
    chk({255'h0, rx_push_ready}, 256'h0);
    rd(rpfs_pkg::ADDR_FIFO_FLAGS, 8'h02);
    cmd(rpfs_pkg::CMD_RD_RX, 8'h00, 8'h00, 256'h0);
    wait_hi(rsp_valid);
    chk(rsp_payload, pl(8'hA0));
    rd(rpfs_pkg::ADDR_FIFO_FLAGS, 8'h00);
    cmd(rpfs_pkg::CMD_FLUSH_RX, 8'h00, 8'h00, 256'h0);
    rd(rpfs_pkg::ADDR_FIFO_FLAGS, 8'h01);
    cmd(rpfs_pkg::CMD_WR_ACK, 8'h00, 8'h00, pl(8'hC3));
    @(negedge clk);
    chk({255'h0, ack_valid}, 256'h1);
    chk(ack_data, pl(8'hC3));
    ack_pop = 1'b1;
    @(negedge clk);
    ack_pop = 1'b0;
    @(negedge clk);
    chk({255'h0, ack_valid}, 256'h0);
    complete_run();
  end
endmodule : test_radio_payload_fifo_status
